// >>> drb_map.svh
/*
 * Constants for the dual-button delayed reset block: timing figures,
 * register offsets, field positions and reset values.
 * Assumes a 25 MHz system clock and a 32-bit APB register port.
 */
// Summary of operation
// - A button input counts as pressed when low and released when high.
// - Apart from test entry, reset asserts only after both buttons stay pressed together for the hold delay.
// - Hold delay is a build-time constant, 0.5 s to 10 s in 0.5 s steps.
// - Button-controlled option: reset ends as soon as either button is released.
// - Fixed option: reset lasts exactly the pulse duration, buttons ignored meanwhile.
// - Reset output polarity is a build-time choice, low-active or high-active.
// - Without valid supply, buttons are ignored and the reset output goes inactive.
// - Overvoltage on the primary button starts a 42 ms test-entry delay.
// - After test entry delay, reset asserts for the pulse or while overvoltage lasts.
// - In test mode the hold delay is shortened to 21 ms.
// - Test mode stays latched until a power cycle, here the reset input.
// - Fixed pulse duration is 1.28 ms, 100 ms, 210 ms or 360 ms.
`ifndef DRB_MAP_SVH
`define DRB_MAP_SVH

`define DRB_CLK_NS 40
`define DRB_TICK_US 10
`define DRB_TICK_CYC ((`DRB_TICK_US * 1000) / `DRB_CLK_NS)
`define DRB_HOLD_STEP_US 500000
`define DRB_HOLD_STEPS_MIN 1
`define DRB_HOLD_STEPS_MAX 20
`define DRB_PULSE_A_US 1280
`define DRB_PULSE_B_US 100000
`define DRB_PULSE_C_US 210000
`define DRB_PULSE_D_US 360000
`define DRB_TEST_ENTRY_US 42000
`define DRB_TEST_HOLD_US 21000

`define DRB_OFS_CTRL 8'h00
`define DRB_OFS_STATUS 8'h04
`define DRB_OFS_COUNT 8'h08
`define DRB_OFS_CFG 8'h0C

`define DRB_CTRL_EN_BIT 0
`define DRB_CTRL_RESET 1'b1

`define DRB_ST_STATE_LSB 0
`define DRB_ST_TEST_BIT 3
`define DRB_ST_ACTIVE_BIT 4
`define DRB_ST_PRESS0_BIT 5
`define DRB_ST_PRESS1_BIT 6
`define DRB_ST_SUPPLY_BIT 7
`define DRB_ST_OVR_BIT 8

`define DRB_CFG_HOLD_LSB 0
`define DRB_CFG_PULSE_LSB 8
`define DRB_CFG_POL_BIT 16

`endif

// >>> drb_pkg.sv
/*
 * Types for the dual-button delayed reset block.
 * Assumes drb_map.svh carries all numeric constants.
 */
package drb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_HOLD = 3'h1,
		ST_PULSE = 3'h3,
		ST_WAIT = 3'h2,
		ST_ENTRY = 3'h6,
		ST_ENTRY_PULSE = 3'h7,
		ST_ENTRY_WAIT = 3'h5
	} drb_state_e;

	typedef enum logic [2:0] {
		PULSE_BUTTON = 3'h0,
		PULSE_1MS28 = 3'h1,
		PULSE_100MS = 3'h2,
		PULSE_210MS = 3'h3,
		PULSE_360MS = 3'h4
	} drb_pulse_e;

	typedef logic [19:0] drb_cnt_t;

endpackage

// >>> drb_sync.sv
/*
 * Two-flop synchroniser, one per bit, for pins from outside the clock domain.
 * Assumes the inputs are slow levels; pulses shorter than one clock may be lost.
 */
module drb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					meta_q <= RST_VAL[i];
					sync_q <= RST_VAL[i];
				end else begin
					meta_q <= din[i];
					sync_q <= meta_q;
				end
			end
			assign dout[i] = sync_q;
		end
	endgenerate

endmodule

// >>> drb_top.sv
/*
 * Dual-button delayed reset generator with test mode and APB status port.
 * Assumes button, supply-valid and overvoltage-detect pins are asynchronous
 * levels, and that resetn is asserted on every power-up.
 */
// Our own choices: the address map and register access over APB.
`include "drb_map.svh"

module drb_top #(
	parameter int unsigned HOLD_STEPS = 8,
	parameter drb_pkg::drb_pulse_e PULSE_SEL = drb_pkg::PULSE_BUTTON,
	parameter bit ACTIVE_HIGH = 1'b0,
	parameter int unsigned TICK_CYC = `DRB_TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic primary_button_n,
	input wire logic secondary_button_n,
	input wire logic supply_valid,
	input wire logic test_entry_level,
	output logic reset_out,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// Timer targets in timebase ticks
	localparam int unsigned HOLD_TICKS = HOLD_STEPS * (`DRB_HOLD_STEP_US / `DRB_TICK_US);
	localparam int unsigned TEST_HOLD_TICKS = `DRB_TEST_HOLD_US / `DRB_TICK_US;
	localparam int unsigned ENTRY_TICKS = `DRB_TEST_ENTRY_US / `DRB_TICK_US;
	localparam int unsigned PULSE_US =
		(PULSE_SEL == drb_pkg::PULSE_1MS28) ? `DRB_PULSE_A_US :
		(PULSE_SEL == drb_pkg::PULSE_100MS) ? `DRB_PULSE_B_US :
		(PULSE_SEL == drb_pkg::PULSE_210MS) ? `DRB_PULSE_C_US :
		`DRB_PULSE_D_US;
	localparam int unsigned PULSE_TICKS = PULSE_US / `DRB_TICK_US;
	localparam bit FIXED = (PULSE_SEL != drb_pkg::PULSE_BUTTON);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
	localparam drb_pkg::drb_cnt_t HOLD_T = drb_pkg::drb_cnt_t'(HOLD_TICKS);
	localparam drb_pkg::drb_cnt_t TEST_HOLD_T = drb_pkg::drb_cnt_t'(TEST_HOLD_TICKS);
	localparam drb_pkg::drb_cnt_t ENTRY_T = drb_pkg::drb_cnt_t'(ENTRY_TICKS);
	localparam drb_pkg::drb_cnt_t PULSE_T = drb_pkg::drb_cnt_t'(PULSE_TICKS);
	localparam drb_pkg::drb_cnt_t CNT_MAX = '1;

	// Pin synchronisers; buttons idle high, detectors idle low
	logic [3:0] pins_async;
	logic [3:0] pins_sync;
	assign pins_async = {test_entry_level, supply_valid, secondary_button_n, primary_button_n};

	drb_sync #(
		.W(4),
		.RST_VAL(4'h3)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din(pins_async),
		.dout(pins_sync)
	);

	wire pressed0 = ~pins_sync[0];
	wire pressed1 = ~pins_sync[1];
	wire both = pressed0 & pressed1;
	wire supply_ok = pins_sync[2];
	wire ovr = pins_sync[3];

	// Registers
	drb_pkg::drb_state_e state_q, state_d;
	drb_pkg::drb_cnt_t cnt_q, cnt_d;
	logic [15:0] div_q, div_d;
	logic test_mode_q, test_mode_d;
	logic rst_out_q, rst_out_d;
	logic ctrl_en_q, ctrl_en_d;
	logic [31:0] prdata_q, prdata_d;

	// Enable bit lets software hold the block off, same as a supply drop
	wire gate_ok = supply_ok & ctrl_en_q;

	// Timebase divider restarts on every state change so each delay is exact
	wire state_chg = (state_d != state_q);
	wire tick = (div_q == TICK_LAST);
	assign div_d = (state_chg || tick) ? 16'h0000 : div_q + 16'h0001;

	wire timed = (state_q == drb_pkg::ST_HOLD) || (state_q == drb_pkg::ST_PULSE) ||
		(state_q == drb_pkg::ST_ENTRY) || (state_q == drb_pkg::ST_ENTRY_PULSE);
	assign cnt_d = state_chg ? '0 :
		(timed && tick && cnt_q != CNT_MAX) ? cnt_q + 20'h00001 : cnt_q;

	wire drb_pkg::drb_cnt_t hold_tgt = test_mode_q ? TEST_HOLD_T : HOLD_T;
	wire drb_pkg::drb_cnt_t tgt =
		(state_q == drb_pkg::ST_HOLD) ? hold_tgt :
		(state_q == drb_pkg::ST_ENTRY) ? ENTRY_T : PULSE_T;
	wire expired = (cnt_q >= tgt);

	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			drb_pkg::ST_IDLE: begin
				if (ovr && !test_mode_q)
					state_d = drb_pkg::ST_ENTRY;
				else if (both)
					state_d = drb_pkg::ST_HOLD;
			end
			drb_pkg::ST_HOLD: begin
				if (!both)
					state_d = drb_pkg::ST_IDLE;
				else if (expired)
					state_d = drb_pkg::ST_PULSE;
			end
			drb_pkg::ST_PULSE: begin
				if (FIXED && expired)
					state_d = drb_pkg::ST_WAIT;
				else if (!FIXED && !both)
					state_d = drb_pkg::ST_IDLE;
			end
			drb_pkg::ST_WAIT: begin
				// A held pair must be released before another reset can start
				if (!both)
					state_d = drb_pkg::ST_IDLE;
			end
			drb_pkg::ST_ENTRY: begin
				if (!ovr)
					state_d = drb_pkg::ST_IDLE;
				else if (expired)
					state_d = drb_pkg::ST_ENTRY_PULSE;
			end
			drb_pkg::ST_ENTRY_PULSE: begin
				if (FIXED && expired)
					state_d = drb_pkg::ST_ENTRY_WAIT;
				else if (!FIXED && !ovr)
					state_d = drb_pkg::ST_IDLE;
			end
			drb_pkg::ST_ENTRY_WAIT: begin
				if (!ovr)
					state_d = drb_pkg::ST_IDLE;
			end
			default: begin
				state_d = drb_pkg::ST_IDLE;
			end
		endcase
		if (!gate_ok)
			state_d = drb_pkg::ST_IDLE;
	end

	// Only the reset input clears test mode, standing in for a power cycle
	assign test_mode_d = test_mode_q |
		(gate_ok && state_q == drb_pkg::ST_ENTRY && ovr && expired);

	wire rst_act_d = (state_d == drb_pkg::ST_PULSE) || (state_d == drb_pkg::ST_ENTRY_PULSE);
	wire rst_act_w = (state_q == drb_pkg::ST_PULSE) || (state_q == drb_pkg::ST_ENTRY_PULSE);
	assign rst_out_d = ACTIVE_HIGH ? rst_act_d : ~rst_act_d;
	assign reset_out = rst_out_q;

	// APB slave: zero wait states, error on unmapped offsets
	wire hit_ctrl = (paddr == `DRB_OFS_CTRL);
	wire hit_status = (paddr == `DRB_OFS_STATUS);
	wire hit_count = (paddr == `DRB_OFS_COUNT);
	wire hit_cfg = (paddr == `DRB_OFS_CFG);
	wire hit_any = hit_ctrl | hit_status | hit_count | hit_cfg;
	wire setup_rd = psel & ~penable & ~pwrite;
	wire access = psel & penable;
	wire wr_ctrl = access & pwrite & hit_ctrl;

	assign ctrl_en_d = wr_ctrl ? pwdata[`DRB_CTRL_EN_BIT] : ctrl_en_q;

	wire [31:0] rd_ctrl = {31'h00000000, ctrl_en_q};
	wire [31:0] rd_status = {23'h000000, ovr, supply_ok, pressed1, pressed0,
		rst_act_w, test_mode_q, state_q};
	wire [31:0] rd_count = {12'h000, cnt_q};
	wire [31:0] rd_cfg = {15'h0000, ACTIVE_HIGH, 5'h00, PULSE_SEL, 3'h0, 5'(HOLD_STEPS)};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_status ? rd_status :
		hit_count ? rd_count : hit_cfg ? rd_cfg : 32'h00000000;
	assign prdata_d = setup_rd ? rd_mux : prdata_q;

	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;
	assign prdata = prdata_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= drb_pkg::ST_IDLE;
			cnt_q <= '0;
			div_q <= 16'h0000;
			test_mode_q <= 1'b0;
			rst_out_q <= ~ACTIVE_HIGH;
			ctrl_en_q <= `DRB_CTRL_RESET;
			prdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			test_mode_q <= test_mode_d;
			rst_out_q <= rst_out_d;
			ctrl_en_q <= ctrl_en_d;
			prdata_q <= prdata_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	chk_press_starts_hold: assert property (
		(state_q == drb_pkg::ST_IDLE && gate_ok && !ovr && !pins_sync[0] && !pins_sync[1])
		|=> state_q == drb_pkg::ST_HOLD)
		else $error("both low buttons did not start the hold timer");

	chk_hold_full_delay: assert property (
		(state_q == drb_pkg::ST_PULSE && $past(state_q) == drb_pkg::ST_HOLD)
		|-> ($past(cnt_q) >= $past(hold_tgt) && $past(both)))
		else $error("reset asserted before the hold delay elapsed");

	chk_release_ends: assert property (
		(!FIXED && state_q == drb_pkg::ST_PULSE && !both)
		|=> !rst_act_w ##0 reset_out == ~ACTIVE_HIGH)
		else $error("button release did not end the reset pulse");

	chk_fixed_length: assert property (
		(FIXED && gate_ok && state_q == drb_pkg::ST_PULSE && cnt_q < PULSE_T)
		|=> state_q == drb_pkg::ST_PULSE)
		else $error("fixed reset pulse ended early");

	chk_out_polarity: assert property (
		rst_act_w |-> reset_out == ACTIVE_HIGH)
		else $error("reset output has the wrong active level");

	chk_supply_release: assert property (
		!gate_ok |=> (!rst_act_w && cnt_q == '0 && reset_out == ~ACTIVE_HIGH))
		else $error("reset output not released without supply");

	chk_entry_start: assert property (
		(state_q == drb_pkg::ST_IDLE && gate_ok && ovr && !test_mode_q)
		|=> (state_q == drb_pkg::ST_ENTRY && cnt_q == '0))
		else $error("overvoltage did not start the test-entry delay");

	chk_entry_pulse: assert property (
		(state_q == drb_pkg::ST_ENTRY && gate_ok && ovr && cnt_q >= ENTRY_T)
		|=> (rst_act_w && test_mode_q))
		else $error("test entry did not assert reset");

	chk_short_hold: assert property (
		(test_mode_q && state_q == drb_pkg::ST_HOLD && both && gate_ok
			&& cnt_q >= TEST_HOLD_T)
		|=> state_q == drb_pkg::ST_PULSE)
		else $error("test mode hold delay not shortened");

	chk_test_latched: assert property (
		test_mode_q |=> test_mode_q)
		else $error("test mode left without a power cycle");

	chk_hold_restart: assert property (
		(state_q == drb_pkg::ST_HOLD && !both) |=> (cnt_q == '0 && !rst_act_w))
		else $error("hold count not restarted after release");

	cov_normal_reset: cover property (
		state_q == drb_pkg::ST_HOLD ##1 state_q == drb_pkg::ST_PULSE);
	cov_short_press: cover property (
		state_q == drb_pkg::ST_HOLD ##1 state_q == drb_pkg::ST_IDLE);
	cov_test_entry: cover property ($rose(test_mode_q));
	cov_supply_drop: cover property (rst_act_w ##1 !gate_ok);

endmodule

// >>> drb_partner.sv
/*
 * Far-side model: two push-buttons and the processor reset input.
 * Assumes the bench commands presses; measures each active reset pulse.
 */
module drb_partner #(
	parameter bit ACTIVE_HIGH = 1'h0
) (
	input wire logic clk_sys,
	input wire logic press_a,
	input wire logic press_b,
	input wire logic single,
	input wire logic overvolt,
	input wire logic reset_out,
	output logic primary_button_n,
	output logic secondary_button_n,
	output logic test_entry_level,
	output logic [31:0] last_width
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] run_q = 32'h0;
	// A closed switch pulls to ground; overvoltage lifts the line above released
	assign primary_button_n = overvolt | ~press_a;
	assign secondary_button_n = single ? primary_button_n : ~press_b;
	assign test_entry_level = overvolt;
	initial last_width = 32'h0;
	always @(posedge clk_sys) begin
		if (reset_out === ACTIVE_HIGH) begin
			run_q <= run_q + 32'h1;
		end else if (run_q != 32'h0) begin
			last_width <= run_q;
			run_q <= 32'h0;
		end
	end
endmodule

// >>> drb_tb_top.sv
/*
 * Self-checking bench for drb_top: register rows, then hold, pulse,
 * test-mode, supply and power-cycle cases. Assumes one clock per tick.
 */
module drb_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} drb_row_s;
	localparam int HOLD_CYC = 50000;
	localparam int ENTRY_CYC = 4200;
	localparam int TEST_HOLD_CYC = 2100;
	// Covers two synchroniser flops and the registered output
	localparam int SLACK = 8;
	logic clk_sys = 1'h0;
	logic resetn = 1'h0;
	logic supply_valid = 1'h1;
	logic press_a = 1'h0;
	logic press_b = 1'h0;
	logic single = 1'h0;
	logic overvolt = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic primary_button_n, secondary_button_n, test_entry_level, reset_out, pready, pslverr;
	logic [31:0] prdata, last_width, rd;
	logic err;
	int fails = 0;
	int comparisons = 0;
	int n;
	drb_row_s rows [9] = '{
		'{1'h0, 8'h0C, 32'h0, 32'h0001_0101, 1'h0},
		'{1'h0, 8'h04, 32'h0, 32'h0000_0080, 1'h0},
		'{1'h0, 8'h00, 32'h0, 32'h0000_0001, 1'h0},
		'{1'h1, 8'h00, 32'h0, 32'h0, 1'h0},
		'{1'h0, 8'h00, 32'h0, 32'h0, 1'h0},
		'{1'h1, 8'h00, 32'h1, 32'h0, 1'h0},
		'{1'h1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'h0},
		'{1'h0, 8'h0C, 32'h0, 32'h0001_0101, 1'h0},
		'{1'h0, 8'h10, 32'h0, 32'h0, 1'h1}};
	always #20 clk_sys = ~clk_sys;
	drb_top #(.HOLD_STEPS(1), .PULSE_SEL(drb_pkg::PULSE_1MS28), .ACTIVE_HIGH(1'h1), .TICK_CYC(1))
		drb_top_inst (.clk_sys(clk_sys), .resetn(resetn), .primary_button_n(primary_button_n),
		.secondary_button_n(secondary_button_n), .supply_valid(supply_valid),
		.test_entry_level(test_entry_level), .reset_out(reset_out), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	drb_partner #(.ACTIVE_HIGH(1'h1)) drb_partner_inst (.clk_sys(clk_sys), .press_a(press_a),
		.press_b(press_b), .single(single), .overvolt(overvolt), .reset_out(reset_out),
		.primary_button_n(primary_button_n), .secondary_button_n(secondary_button_n),
		.test_entry_level(test_entry_level), .last_width(last_width));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 20) begin
			fails++;
			complete_run();
		end
	endtask
	// n ends at lim when the level never came; must makes that a failure
	task wait_out(input logic lvl, input int lim, input bit must);
		n = 0;
		while (reset_out !== lvl && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		if (must && n == lim) begin
			fails++;
			$display("[FAIL] %0t ns: reset output wait ran out", $time);
			complete_run();
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		check(reset_out, 1'h0);
		resetn <= 1'h1;
		repeat (3) @(posedge clk_sys);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) check(rd, rows[i].exp);
			check(err, rows[i].err);
		end
		$display("Register rows done");
		single <= 1'h1;
		press_a <= 1'h1;
		repeat (1000) @(posedge clk_sys);
		press_a <= 1'h0;
		repeat (5) @(posedge clk_sys);
		check(reset_out, 1'h0);
		press_a <= 1'h1;
		wait_out(1'h1, HOLD_CYC + 40, 1'h1);
		check(n >= HOLD_CYC && n <= HOLD_CYC + SLACK, 1'h1);
		repeat (10) @(posedge clk_sys);
		press_a <= 1'h0;
		wait_out(1'h0, 300, 1'h1);
		repeat (2) @(posedge clk_sys);
		check(last_width >= 127 && last_width <= 130, 1'h1);
		single <= 1'h0;
		$display("Hold and fixed pulse done");
		overvolt <= 1'h1;
		wait_out(1'h1, ENTRY_CYC + 40, 1'h1);
		check(n >= ENTRY_CYC && n <= ENTRY_CYC + SLACK, 1'h1);
		wait_out(1'h0, 300, 1'h1);
		repeat (2) @(posedge clk_sys);
		check(last_width >= 127 && last_width <= 130, 1'h1);
		overvolt <= 1'h0;
		apb(1'h0, 8'h04, 32'h0);
		check(rd[3], 1'h1);
		$display("Test entry done");
		press_a <= 1'h1;
		wait_out(1'h1, 3000, 1'h0);
		check(n, 3000);
		press_b <= 1'h1;
		wait_out(1'h1, TEST_HOLD_CYC + 40, 1'h1);
		check(n >= TEST_HOLD_CYC && n <= TEST_HOLD_CYC + SLACK, 1'h1);
		repeat (5) @(posedge clk_sys);
		supply_valid <= 1'h0;
		wait_out(1'h0, 6, 1'h1);
		check(n <= 5, 1'h1);
		wait_out(1'h1, 3000, 1'h0);
		check(n, 3000);
		press_a <= 1'h0;
		press_b <= 1'h0;
		supply_valid <= 1'h1;
		resetn <= 1'h0;
		repeat (8) @(posedge clk_sys);
		check(reset_out, 1'h0);
		resetn <= 1'h1;
		repeat (4) @(posedge clk_sys);
		apb(1'h0, 8'h04, 32'h0);
		check(rd, 32'h0000_0080);
		$display("Supply and power cycle done");
		complete_run();
	end
endmodule
